// ---- shared/ddc_map.svh ----
// field positions, codes and timing counts of the dual dac serial link
`ifndef DDC_MAP_SVH
`define DDC_MAP_SVH
`define DDC_FRAME_BITS 24
`define DDC_LAST_CNT 5'd23
`define DDC_FULL_CNT 5'd24
`define DDC_RD_BIT 23
`define DDC_REG_FIELD 21:19
`define DDC_ADDR_FIELD 18:16
`define DDC_DATA_FIELD 15:0
`define DDC_REG_FUNC 3'h0
`define DDC_REG_DATA 3'h2
`define DDC_REG_AUX 3'h3
`define DDC_ADDR_A 3'h0
`define DDC_ADDR_B 3'h1
`define DDC_ADDR_ALL 3'h4
`define DDC_FUNC_CHAIN_BIT 0
`define DDC_AUX_DIR_FIELD 1:0
`define DDC_AUX_LVL_FIELD 3:2
`define DDC_AUX_PIN_FIELD 5:4
`define DDC_CLEAR_CODE 16'h0000
`define DDC_AUX_DIR_RST 2'h0
`define DDC_AUX_LVL_RST 2'h0
`define DDC_MCLK_NS 10
`define DDC_SCLK_MIN_NS 33
`define DDC_SYNC_HIGH_NS 90
`define DDC_SYNC_HOLD_NS 13
`define DDC_SCLK_HALF_CYC ((`DDC_SCLK_MIN_NS + 2 * `DDC_MCLK_NS - 1) / (2 * `DDC_MCLK_NS))
`define DDC_GAP_CYC ((`DDC_SYNC_HIGH_NS + `DDC_MCLK_NS - 1) / `DDC_MCLK_NS)
`define DDC_HOLD_CYC ((`DDC_SYNC_HOLD_NS + `DDC_MCLK_NS - 1) / `DDC_MCLK_NS)
`endif

// ---- shared/ddc_pkg.sv ----
// types shared by both ends of the dual dac serial link
package ddc_pkg;
    typedef logic [23:0] ddc_word_t;
    typedef logic [15:0] ddc_code_t;
    typedef enum logic [2:0] {H_IDLE, H_SETUP, H_LOW, H_HIGH, H_HOLD, H_GAP} ddc_host_state_t;
endpackage : ddc_pkg

// ---- shared/ddc_link_if.sv ----
// pins between the host serial port and the dual dac control
`timescale 1ns/1ps
interface ddc_link_if;
    logic serial_clk;
    logic frame_n;
    logic serial_data_in;
    logic serial_data_out;
    logic load_outputs_n;
    logic output_clamp_in;
    logic monitor_reset_out;
    logic clear_host_out;
    logic clear_host_oe_n;
    logic clear_n;
    logic [1:0] aux_dev_out;
    logic [1:0] aux_dev_oe_n;
    logic [1:0] aux_host_out;
    logic [1:0] aux_host_oe_n;
    logic aux_io_bit0;
    logic aux_io_bit1;
    // pull-up on clear: a released pin reads high and never clears
    assign clear_n = !clear_host_oe_n ? clear_host_out : 1'b1;
    assign aux_io_bit0 = !aux_dev_oe_n[0] ? aux_dev_out[0] : (!aux_host_oe_n[0] ? aux_host_out[0] : 1'b1);
    assign aux_io_bit1 = !aux_dev_oe_n[1] ? aux_dev_out[1] : (!aux_host_oe_n[1] ? aux_host_out[1] : 1'b1);
    modport dev (
        input serial_clk, frame_n, serial_data_in, load_outputs_n, output_clamp_in, clear_n,
        input aux_io_bit0, aux_io_bit1,
        output serial_data_out, monitor_reset_out, aux_dev_out, aux_dev_oe_n
    );
    modport host (
        output serial_clk, frame_n, serial_data_in, load_outputs_n, output_clamp_in,
        output clear_host_out, clear_host_oe_n, aux_host_out, aux_host_oe_n,
        input serial_data_out, monitor_reset_out, aux_io_bit0, aux_io_bit1
    );
endinterface : ddc_link_if

// ---- design/ddc_sync2.sv ----
// two flip-flop level synchroniser
`timescale 1ns/1ps
module ddc_sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= RST;
            q <= RST;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule : ddc_sync2

// ---- design/ddc_dev_end.sv ----
// device end: serial load, double-buffered dac registers, clear, aux port
`timescale 1ns/1ps
`include "ddc_map.svh"
module ddc_dev_end (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic supply_good,
    ddc_link_if.dev link,
    output ddc_pkg::ddc_code_t dac_code_a,
    output ddc_pkg::ddc_code_t dac_code_b,
    output logic outputs_clamped,
    output logic chain_mode
);
    import ddc_pkg::*;

    // ---------- link domain, clocked by the serial clock ----------
    logic link_rst;
    logic [4:0] cnt_reg;
    logic [4:0] cnt_next;
    ddc_word_t sr_reg;
    ddc_word_t sr_next;
    ddc_word_t word_reg;
    ddc_word_t word_next;
    ddc_word_t base;
    logic tgl_reg;
    logic tgl_next;
    logic sdo_reg;
    logic sdo_next;
    // mclk-side values read by the link side; they only change in the frame gap
    ddc_word_t rb_word_reg;
    logic rb_armed_reg;
    logic chain_reg;

    // a high frame holds the bit counter at zero, so a new frame always starts clean
    assign link_rst = link.frame_n | ~rst_n;

    always_comb begin
        base = (cnt_reg == 5'd0 && rb_armed_reg) ? rb_word_reg : sr_reg;
        sr_next = sr_reg;
        word_next = word_reg;
        tgl_next = tgl_reg;
        cnt_next = cnt_reg;
        sdo_next = sdo_reg;
        if (!link.frame_n) begin
            sr_next = {base[22:0], link.serial_data_in};
            if (cnt_reg < `DDC_FULL_CNT) begin
                cnt_next = cnt_reg + 5'd1;
            end
            // keeps the last 24 bits, so longer chained frames still work
            if (cnt_reg >= `DDC_LAST_CNT) begin
                word_next = {base[22:0], link.serial_data_in};
            end
            if (cnt_reg == `DDC_LAST_CNT) begin
                tgl_next = ~tgl_reg;
            end
            sdo_next = (chain_reg | rb_armed_reg) ? base[23] : 1'b0;
        end
    end

    always_ff @(negedge link.serial_clk or posedge link_rst) begin
        if (link_rst) begin
            cnt_reg <= 5'd0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    always_ff @(negedge link.serial_clk or negedge rst_n) begin
        if (!rst_n) begin
            sr_reg <= '0;
            word_reg <= '0;
            tgl_reg <= 1'b0;
            sdo_reg <= 1'b0;
        end else begin
            sr_reg <= sr_next;
            word_reg <= word_next;
            tgl_reg <= tgl_next;
            sdo_reg <= sdo_next;
        end
    end

    assign link.serial_data_out = sdo_reg;

    // ---------- core domain on mclk ----------
    logic [7:0] raw_in;
    logic [7:0] syn;
    logic s_frame;
    logic s_tgl;
    logic s_clear;
    logic s_load;
    logic s_clamp;
    logic s_supply;
    logic [1:0] s_aux;

    assign raw_in = {link.aux_io_bit1, link.aux_io_bit0, supply_good, link.output_clamp_in,
                     link.load_outputs_n, link.clear_n, tgl_reg, link.frame_n};

    ddc_sync2 #(.W(8), .RST(8'hdd)) u_sync (
        .clk(mclk),
        .rst_n(rst_n),
        .d(raw_in),
        .q(syn)
    );

    assign s_frame = syn[0];
    assign s_tgl = syn[1];
    assign s_clear = syn[2];
    assign s_load = syn[3];
    assign s_clamp = syn[4];
    assign s_supply = syn[5];
    assign s_aux = syn[7:6];

    logic frame_q_reg;
    logic frame_q2_reg;
    logic tgl_seen_reg;
    logic tgl_seen_next;
    logic clear_q_reg;
    logic load_q_reg;
    ddc_code_t inp_reg [2];
    ddc_code_t inp_next [2];
    ddc_code_t dac_reg [2];
    ddc_code_t dac_next [2];
    logic [1:0] pend_reg;
    logic [1:0] pend_next;
    logic [1:0] aux_oen_reg;
    logic [1:0] aux_oen_next;
    logic [1:0] aux_lvl_reg;
    logic [1:0] aux_lvl_next;
    ddc_word_t rb_word_next;
    logic rb_armed_next;
    logic chain_next;
    ddc_code_t code_a_reg;
    ddc_code_t code_b_reg;
    logic clamped_reg;
    logic mon_reg;
    logic frame_end;
    logic load_fall;
    logic clear_fall;
    logic [2:0] reg_sel;
    logic [2:0] addr;
    ddc_code_t data;
    logic hit;

    assign reg_sel = word_reg[`DDC_REG_FIELD];
    assign addr = word_reg[`DDC_ADDR_FIELD];
    assign data = word_reg[`DDC_DATA_FIELD];
    // one cycle behind the synchronised frame so the word toggle has surely landed
    assign frame_end = frame_q_reg & ~frame_q2_reg;
    assign load_fall = load_q_reg & ~s_load;
    assign clear_fall = clear_q_reg & ~s_clear;

    always_comb begin
        tgl_seen_next = tgl_seen_reg;
        inp_next = inp_reg;
        dac_next = dac_reg;
        pend_next = pend_reg;
        aux_oen_next = aux_oen_reg;
        aux_lvl_next = aux_lvl_reg;
        rb_word_next = rb_word_reg;
        rb_armed_next = rb_armed_reg;
        chain_next = chain_reg;
        hit = 1'b0;
        if (frame_end) begin
            rb_armed_next = 1'b0;
            if (s_tgl != tgl_seen_reg) begin // short frames never toggle and are dropped
                tgl_seen_next = s_tgl;
                if (word_reg[`DDC_RD_BIT]) begin
                    rb_armed_next = 1'b1;
                    rb_word_next = {word_reg[23:16], 16'h0000};
                    if (reg_sel == `DDC_REG_DATA) begin
                        rb_word_next[`DDC_DATA_FIELD] = (addr == `DDC_ADDR_B) ? dac_reg[1] : dac_reg[0];
                    end else if (reg_sel == `DDC_REG_AUX) begin
                        rb_word_next[`DDC_AUX_DIR_FIELD] = ~aux_oen_reg;
                        rb_word_next[`DDC_AUX_LVL_FIELD] = aux_lvl_reg;
                        rb_word_next[`DDC_AUX_PIN_FIELD] = s_aux;
                    end else if (reg_sel == `DDC_REG_FUNC) begin
                        rb_word_next[`DDC_FUNC_CHAIN_BIT] = chain_reg;
                    end
                end else if (reg_sel == `DDC_REG_DATA) begin
                    for (int ch = 0; ch < 2; ch++) begin
                        hit = (addr == `DDC_ADDR_ALL) || (addr == 3'(ch));
                        if (hit) begin
                            inp_next[ch] = data;
                            if (!s_load) begin
                                dac_next[ch] = data;
                                pend_next[ch] = 1'b0;
                            end else begin
                                pend_next[ch] = 1'b1;
                            end
                        end
                    end
                end else if (reg_sel == `DDC_REG_AUX) begin
                    aux_oen_next = ~data[`DDC_AUX_DIR_FIELD];
                    aux_lvl_next = data[`DDC_AUX_LVL_FIELD];
                end else if (reg_sel == `DDC_REG_FUNC) begin
                    chain_next = data[`DDC_FUNC_CHAIN_BIT];
                end
            end
        end
        if (load_fall) begin
            for (int ch = 0; ch < 2; ch++) begin
                if (pend_reg[ch]) begin
                    dac_next[ch] = inp_reg[ch];
                end
            end
            pend_next = 2'b00;
        end
        // edge detect only: a held-low clear does not block later writes
        if (clear_fall) begin
            dac_next[0] = `DDC_CLEAR_CODE;
            dac_next[1] = `DDC_CLEAR_CODE;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            frame_q_reg <= 1'b1;
            frame_q2_reg <= 1'b1;
            tgl_seen_reg <= 1'b0;
            clear_q_reg <= 1'b1;
            load_q_reg <= 1'b1;
            inp_reg[0] <= `DDC_CLEAR_CODE;
            inp_reg[1] <= `DDC_CLEAR_CODE;
            dac_reg[0] <= `DDC_CLEAR_CODE;
            dac_reg[1] <= `DDC_CLEAR_CODE;
            pend_reg <= 2'b00;
            aux_oen_reg <= ~`DDC_AUX_DIR_RST;
            aux_lvl_reg <= `DDC_AUX_LVL_RST;
            rb_word_reg <= '0;
            rb_armed_reg <= 1'b0;
            chain_reg <= 1'b0;
            code_a_reg <= `DDC_CLEAR_CODE;
            code_b_reg <= `DDC_CLEAR_CODE;
            clamped_reg <= 1'b1;
            mon_reg <= 1'b0;
        end else begin
            frame_q_reg <= s_frame;
            frame_q2_reg <= frame_q_reg;
            tgl_seen_reg <= tgl_seen_next;
            clear_q_reg <= s_clear;
            load_q_reg <= s_load;
            inp_reg <= inp_next;
            dac_reg <= dac_next;
            pend_reg <= pend_next;
            aux_oen_reg <= aux_oen_next;
            aux_lvl_reg <= aux_lvl_next;
            rb_word_reg <= rb_word_next;
            rb_armed_reg <= rb_armed_next;
            chain_reg <= chain_next;
            // clamp acts on the output only; dac registers keep their codes
            code_a_reg <= s_clamp ? dac_reg[0] : `DDC_CLEAR_CODE;
            code_b_reg <= s_clamp ? dac_reg[1] : `DDC_CLEAR_CODE;
            clamped_reg <= ~s_clamp;
            mon_reg <= s_supply;
        end
    end

    assign link.aux_dev_out = aux_lvl_reg;
    assign link.aux_dev_oe_n = aux_oen_reg;
    assign link.monitor_reset_out = mon_reg;
    assign dac_code_a = code_a_reg;
    assign dac_code_b = code_b_reg;
    assign outputs_clamped = clamped_reg;
    assign chain_mode = chain_reg;
endmodule : ddc_dev_end

// ---- design/ddc_host_end.sv ----
// host end: serial port master that frames 24-bit words to the dac
`timescale 1ns/1ps
`include "ddc_map.svh"
module ddc_host_end (
    input wire logic mclk,
    input wire logic rst_n,
    ddc_link_if.host link,
    input wire logic cmd_valid,
    input wire ddc_pkg::ddc_word_t cmd_word,
    output logic cmd_ready,
    output ddc_pkg::ddc_word_t rsp_word,
    output logic rsp_valid,
    input wire logic user_load_n,
    input wire logic user_clear,
    input wire logic user_clamp_n,
    input wire logic [1:0] user_aux_level,
    input wire logic [1:0] user_aux_oe_n,
    output logic [1:0] aux_pins_seen,
    output logic monitor_reset_seen
);
    import ddc_pkg::*;

    logic [3:0] syn;
    ddc_sync2 #(.W(4)) u_sync (
        .clk(mclk),
        .rst_n(rst_n),
        .d({link.aux_io_bit1, link.aux_io_bit0, link.monitor_reset_out, link.serial_data_out}),
        .q(syn)
    );

    ddc_host_state_t st_reg;
    ddc_host_state_t st_next;
    logic [3:0] tmr_reg;
    logic [3:0] tmr_next;
    logic [4:0] cnt_reg;
    logic [4:0] cnt_next;
    ddc_word_t sh_reg;
    ddc_word_t sh_next;
    ddc_word_t rx_reg;
    ddc_word_t rx_next;
    logic sclk_reg;
    logic sclk_next;
    logic frame_reg;
    logic frame_next;
    logic sdi_reg;
    logic sdi_next;
    logic rsp_reg;
    logic rsp_next;
    logic ready_reg;
    logic ready_next;
    logic load_reg;
    logic clamp_reg;
    logic clear_reg;
    logic [1:0] aux_lvl_reg;
    logic [1:0] aux_oe_reg;
    logic [1:0] aux_seen_reg;
    logic mon_reg;

    // half period of at least 16.5 ns keeps the clock at or under 30 MHz
    localparam logic [3:0] HALF = 4'(`DDC_SCLK_HALF_CYC - 1);
    localparam logic [3:0] GAP = 4'(`DDC_GAP_CYC - 1);
    localparam logic [3:0] HOLD = 4'(`DDC_HOLD_CYC - 1);

    always_comb begin
        st_next = st_reg;
        tmr_next = (tmr_reg != 4'd0) ? tmr_reg - 4'd1 : tmr_reg;
        cnt_next = cnt_reg;
        sh_next = sh_reg;
        rx_next = rx_reg;
        sclk_next = sclk_reg;
        frame_next = frame_reg;
        sdi_next = sdi_reg;
        rsp_next = 1'b0;
        ready_next = 1'b0;
        case (st_reg)
            H_IDLE: begin
                ready_next = 1'b1;
                if (cmd_valid && ready_reg) begin
                    ready_next = 1'b0;
                    sh_next = cmd_word;
                    sdi_next = cmd_word[23];
                    frame_next = 1'b0;
                    cnt_next = 5'd0;
                    tmr_next = HALF;
                    st_next = H_SETUP;
                end
            end
            H_SETUP: begin
                if (tmr_reg == 4'd0) begin
                    sclk_next = 1'b0;
                    cnt_next = cnt_reg + 5'd1;
                    tmr_next = HALF;
                    st_next = H_LOW;
                end
            end
            H_LOW: begin
                if (tmr_reg == 4'd0) begin
                    sclk_next = 1'b1;
                    tmr_next = HALF;
                    if (cnt_reg == `DDC_FULL_CNT) begin
                        tmr_next = HOLD;
                        st_next = H_HOLD;
                    end else begin
                        sh_next = {sh_reg[22:0], 1'b0};
                        sdi_next = sh_reg[22];
                        st_next = H_HIGH;
                    end
                end
            end
            H_HIGH: begin
                if (tmr_reg == 4'd0) begin
                    rx_next = {rx_reg[22:0], syn[0]};
                    sclk_next = 1'b0;
                    cnt_next = cnt_reg + 5'd1;
                    tmr_next = HALF;
                    st_next = H_LOW;
                end
            end
            H_HOLD: begin
                if (tmr_reg == 4'd0) begin
                    rx_next = {rx_reg[22:0], syn[0]};
                    frame_next = 1'b1;
                    tmr_next = GAP;
                    st_next = H_GAP;
                end
            end
            H_GAP: begin
                if (tmr_reg == 4'd0) begin
                    rsp_next = 1'b1;
                    st_next = H_IDLE;
                end
            end
            default: begin
                st_next = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= H_IDLE;
            tmr_reg <= 4'd0;
            cnt_reg <= 5'd0;
            sh_reg <= '0;
            rx_reg <= '0;
            sclk_reg <= 1'b1;
            frame_reg <= 1'b1;
            sdi_reg <= 1'b0;
            rsp_reg <= 1'b0;
            ready_reg <= 1'b0;
            load_reg <= 1'b1;
            clamp_reg <= 1'b1;
            clear_reg <= 1'b1;
            aux_lvl_reg <= 2'b00;
            aux_oe_reg <= 2'b11;
            aux_seen_reg <= 2'b00;
            mon_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            tmr_reg <= tmr_next;
            cnt_reg <= cnt_next;
            sh_reg <= sh_next;
            rx_reg <= rx_next;
            sclk_reg <= sclk_next;
            frame_reg <= frame_next;
            sdi_reg <= sdi_next;
            rsp_reg <= rsp_next;
            ready_reg <= ready_next;
            load_reg <= user_load_n;
            clamp_reg <= user_clamp_n;
            clear_reg <= ~user_clear;
            aux_lvl_reg <= user_aux_level;
            aux_oe_reg <= user_aux_oe_n;
            aux_seen_reg <= syn[3:2];
            mon_reg <= syn[1];
        end
    end

    assign link.serial_clk = sclk_reg;
    assign link.frame_n = frame_reg;
    assign link.serial_data_in = sdi_reg;
    assign link.load_outputs_n = load_reg;
    assign link.output_clamp_in = clamp_reg;
    // clear is driven only while asserted; released, the pull-up holds it high
    assign link.clear_host_out = 1'b0;
    assign link.clear_host_oe_n = clear_reg;
    assign link.aux_host_out = aux_lvl_reg;
    assign link.aux_host_oe_n = aux_oe_reg;
    assign cmd_ready = ready_reg;
    assign rsp_word = rx_reg;
    assign rsp_valid = rsp_reg;
    assign aux_pins_seen = aux_seen_reg;
    assign monitor_reset_seen = mon_reg;
endmodule : ddc_host_end

// ---- dv/ddc_link_monitor.sv ----
// concurrent checks on the link pins between host end and device end
`timescale 1ns/1ps
module ddc_link_monitor (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic serial_clk,
    input wire logic frame_n,
    input wire logic serial_data_in,
    input wire logic serial_data_out,
    input wire logic clear_host_oe_n,
    input wire logic clear_n,
    input wire logic [1:0] aux_dev_oe_n,
    input wire logic [1:0] aux_host_oe_n,
    input wire logic aux_io_bit0
);
    logic sclk_reg, sclk_next;
    logic [5:0] falls_reg, falls_next;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // falls seen from the mclk side; cleared between frames so a stray edge cannot carry over
    always_comb begin
        sclk_next = serial_clk;
        falls_next = frame_n ? 6'h0 : falls_reg + {5'h0, sclk_reg & !serial_clk};
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_reg <= 1'h1;
            falls_reg <= 6'h0;
        end else begin
            sclk_reg <= sclk_next;
            falls_reg <= falls_next;
        end
    end
    sequence s_lead; serial_clk ##1 serial_clk ##1 !serial_clk; endsequence
    sequence s_low; !serial_clk ##1 serial_clk ##1 serial_clk; endsequence
    property p_frame_lead; $fell(frame_n) |-> s_lead; endproperty
    a_frame_lead: assert property (p_frame_lead) else $error("late first clock fall");
    property p_sclk_rate; $fell(serial_clk) |-> ##1 s_low; endproperty
    a_sclk_rate: assert property (p_sclk_rate) else $error("link clock too fast");
    property p_idle; frame_n && $past(frame_n) |-> serial_clk; endproperty
    a_idle: assert property (p_idle) else $error("link clock moves outside frame");
    property p_sdi; !frame_n && $changed(serial_data_in) |-> $rose(serial_clk) || $fell(frame_n); endproperty
    a_sdi: assert property (p_sdi) else $error("data moved near falling edge");
    property p_len; $rose(frame_n) |-> falls_reg == 6'd24 && serial_clk; endproperty
    a_len: assert property (p_len) else $error("frame not 24 bits");
    property p_gap; $rose(frame_n) |-> frame_n [*8] ##1 frame_n; endproperty
    a_gap: assert property (p_gap) else $error("frame gap too short");
    property p_sdo; $changed(serial_data_out) |-> $fell(serial_clk); endproperty
    a_sdo: assert property (p_sdo) else $error("serial out moved off a fall");
    property p_clear_pull; clear_host_oe_n |-> clear_n; endproperty
    a_clear_pull: assert property (p_clear_pull) else $error("released clear not high");
    property p_aux_pull; aux_dev_oe_n[0] && aux_host_oe_n[0] |-> aux_io_bit0; endproperty
    a_aux_pull: assert property (p_aux_pull) else $error("released aux pin not high");
endmodule : ddc_link_monitor

// ---- dv/testbench.sv ----
// bench: host end and device end over the link, plus a bare second device end
`timescale 1ns/1ps
`include "ddc_map.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; $display("ERROR %s exp %h got %h", n, e, g); end end
module testbench;
    import ddc_pkg::*;
    logic mclk = 1'h0, rst_n = 1'h1, supply_good = 1'h1, cmd_valid = 1'h0;
    logic user_load_n = 1'h0, user_clear = 1'h0, user_clamp_n = 1'h1, m_clamp = 1'h0;
    logic [1:0] user_aux_level = 2'h0, user_aux_oe_n = 2'h3, aux_pins_seen, lv;
    logic outputs_clamped, chain_mode, cmd_ready, rsp_valid, monitor_reset_seen;
    ddc_word_t cmd_word = 24'h0, rsp_word, last_rsp, w;
    ddc_code_t dac_code_a, dac_code_b, b2_a;
    logic [2:0] addrs[3] = '{`DDC_ADDR_A, `DDC_ADDR_B, `DDC_ADDR_ALL};
    int fails = 0, checks = 0, m_dac[2] = '{0, 0}, m_inp[2] = '{0, 0};
    integer seed = 32'h6aa7;
    ddc_link_if link ();
    ddc_link_if link2 ();
    ddc_dev_end u_ddc_dev_end (.mclk, .rst_n, .supply_good, .link(link.dev), .dac_code_a, .dac_code_b,
        .outputs_clamped, .chain_mode);
    ddc_host_end u_ddc_host_end (.mclk, .rst_n, .link(link.host), .cmd_valid, .cmd_word, .cmd_ready, .rsp_word,
        .rsp_valid, .user_load_n, .user_clear, .user_clamp_n, .user_aux_level, .user_aux_oe_n, .aux_pins_seen,
        .monitor_reset_seen);
    ddc_dev_end u_ddc_dev_end_2 (.mclk, .rst_n, .supply_good, .link(link2.dev), .dac_code_a(b2_a), .dac_code_b(),
        .outputs_clamped(), .chain_mode());
    ddc_link_monitor u_ddc_link_monitor (.mclk, .rst_n, .serial_clk(link.serial_clk), .frame_n(link.frame_n),
        .serial_data_in(link.serial_data_in), .serial_data_out(link.serial_data_out),
        .clear_host_oe_n(link.clear_host_oe_n), .clear_n(link.clear_n), .aux_dev_oe_n(link.aux_dev_oe_n),
        .aux_host_oe_n(link.aux_host_oe_n), .aux_io_bit0(link.aux_io_bit0));
    initial forever #5 mclk = ~mclk;
    function automatic ddc_word_t wd(input logic [2:0] r, input logic [2:0] a, input ddc_code_t d);
        return {2'h0, r, a, d};
    endfunction : wd
    function automatic ddc_code_t rnd();
        return 16'($random(seed));
    endfunction : rnd
    task automatic settle();
        repeat (8) @(posedge mclk);
        `CHK("dac_a", ddc_code_t'(m_clamp ? 0 : m_dac[0]), dac_code_a)
        `CHK("dac_b", ddc_code_t'(m_clamp ? 0 : m_dac[1]), dac_code_b)
    endtask : settle
    task automatic xfer(input ddc_word_t x);
        @(posedge mclk);
        if (!x[23] && x[`DDC_REG_FIELD] == `DDC_REG_DATA)
            for (int i = 0; i < 2; i++)
                if (x[`DDC_ADDR_FIELD] == 3'(i) || x[`DDC_ADDR_FIELD] == `DDC_ADDR_ALL) begin
                    m_inp[i] = x[15:0];
                    if (!user_load_n) m_dac[i] = x[15:0];
                end
        cmd_valid <= 1'h1;
        cmd_word <= x;
        for (int n = 0; n < 300; n++) begin
            @(posedge mclk);
            if (cmd_ready === 1'h1) break;
        end
        cmd_valid <= 1'h0;
        for (int n = 0; n < 300; n++) begin
            @(posedge mclk);
            if (rsp_valid === 1'h1) break;
        end
        `CHK("rsp_valid", 1'h1, rsp_valid)
        last_rsp = rsp_word;
        settle();
    endtask : xfer
    // bench-made link clock runs only inside frames, except the stray edges asked for
    task automatic send2(input ddc_word_t x, input int pre, input int nb);
        repeat (pre) begin
            #6 link2.serial_clk = 1'h0;
            link2.serial_data_in = ~link2.serial_data_in;
            #6 link2.serial_clk = 1'h1;
        end
        link2.frame_n = 1'h0;
        #7;
        for (int i = 0; i < nb; i++) begin
            link2.serial_data_in = x[23 - i];
            #6 link2.serial_clk = 1'h0;
            #6 link2.serial_clk = 1'h1;
        end
        #13 link2.frame_n = 1'h1;
        link2.serial_data_in = ~link2.serial_data_in;
        #200;
    endtask : send2
    task automatic end_sim();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim
    // about 25 us of traffic expected; a generous margin before calling it a hang
    initial begin
        #200us;
        fails++;
        end_sim();
    end
    initial begin
        rst_n <= 1'h0;
        link2.serial_clk = 1'h1;
        link2.frame_n = 1'h1;
        link2.serial_data_in = 1'h0;
        link2.load_outputs_n = 1'h0;
        link2.output_clamp_in = 1'h1;
        link2.clear_host_out = 1'h0;
        link2.clear_host_oe_n = 1'h1;
        link2.aux_host_out = 2'h0;
        link2.aux_host_oe_n = 2'h3;
        repeat (16) @(posedge mclk);
        rst_n <= 1'h1;
        repeat (4) @(posedge mclk);
        for (int k = 0; k < 6; k++) xfer(wd(`DDC_REG_DATA, addrs[k % 3], rnd()));
        $display("test direct_update done");
        user_load_n <= 1'h1;
        xfer(wd(`DDC_REG_DATA, `DDC_ADDR_A, rnd()));
        xfer(wd(`DDC_REG_DATA, `DDC_ADDR_B, rnd()));
        user_load_n <= 1'h0;
        m_dac = m_inp;
        settle();
        $display("test deferred_load done");
        xfer(wd(`DDC_REG_DATA, `DDC_ADDR_ALL, rnd()));
        user_clear <= 1'h1;
        m_dac = '{0, 0};
        settle();
        xfer(wd(`DDC_REG_DATA, `DDC_ADDR_A, rnd()));
        user_clear <= 1'h0;
        settle();
        $display("test clear done");
        user_clamp_n <= 1'h0;
        m_clamp = 1'h1;
        settle();
        `CHK("clamped", 1'h1, outputs_clamped)
        xfer(wd(`DDC_REG_DATA, `DDC_ADDR_B, rnd()));
        user_clamp_n <= 1'h1;
        m_clamp = 1'h0;
        settle();
        `CHK("unclamped", 1'h0, outputs_clamped)
        $display("test clamp done");
        supply_good <= 1'h0;
        repeat (8) @(posedge mclk);
        `CHK("monitor_low", 1'h0, monitor_reset_seen)
        supply_good <= 1'h1;
        repeat (8) @(posedge mclk);
        `CHK("monitor_high", 1'h1, monitor_reset_seen)
        $display("test monitor done");
        xfer(wd(`DDC_REG_FUNC, 3'h0, 16'h0001));
        `CHK("chain_on", 1'h1, chain_mode)
        w = wd(`DDC_REG_DATA, `DDC_ADDR_A, rnd());
        xfer(w);
        xfer(wd(`DDC_REG_DATA, `DDC_ADDR_B, rnd()));
        `CHK("chain_out", w, last_rsp)
        xfer(wd(`DDC_REG_FUNC, 3'h0, 16'h0000));
        $display("test chain done");
        lv = 2'($random(seed));
        xfer(wd(`DDC_REG_AUX, 3'h0, {12'h0, lv, 2'h3}));
        `CHK("aux_out", lv, aux_pins_seen)
        user_aux_level <= ~lv;
        user_aux_oe_n <= 2'h0;
        xfer(wd(`DDC_REG_AUX, 3'h0, {12'h0, lv, 2'h0}));
        `CHK("aux_in", ~lv, aux_pins_seen)
        w = {1'h1, 1'h0, `DDC_REG_AUX, 3'h0, 16'h0};
        xfer(w);
        xfer(wd(`DDC_REG_FUNC, 3'h0, 16'h0000));
        `CHK("readback", {w[23:16], ~lv}, {last_rsp[23:16], last_rsp[5:4]})
        user_aux_oe_n <= 2'h3;
        $display("test aux done");
        send2(wd(`DDC_REG_DATA, `DDC_ADDR_A, 16'h5a5a), 0, 23);
        `CHK("short_frame", 16'h0, b2_a)
        send2(wd(`DDC_REG_DATA, `DDC_ADDR_A, 16'h5a5a), 5, 20);
        `CHK("idle_edges", 16'h0, b2_a)
        send2(wd(`DDC_REG_DATA, `DDC_ADDR_A, 16'h5a5a), 0, 24);
        `CHK("full_frame", 16'h5a5a, b2_a)
        `CHK("clear_pull", 1'h1, link2.clear_n)
        $display("test bare_link done");
        end_sim();
    end
endmodule : testbench
